// ===== rtl/ccs_sequencer.sv
/*
 Frame sequencer that drives the sensor gates and tags the sample stream.
 It assumes an analog front end that digitises on sample_strobe_o and a consumer
 that takes tags through a valid/ready handshake.
*/
`timescale 1ns/1ps
module ccs_sequencer (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic parallel_split_i,
    input wire logic [ccs_pkg::CCS_CNT_W-1:0] integ_cycles_i,
    output ccs_pkg::ccs_gates_s gates_o,
    output logic sample_strobe_o,
    output logic busy_o,
    output logic frame_done_o,
    output logic tag_valid_o,
    input wire logic tag_ready_i,
    output ccs_pkg::ccs_sample_s tag_o
);
    import ccs_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_COLLECT, ST_FLUSH, ST_DUMP, ST_RELEASE, ST_SETTLE,
        ST_INTEG, ST_V1, ST_V2, ST_XFER, ST_HHIGH, ST_HLOW, ST_RESET
    } ccs_state_e;

    ccs_state_e state;
    ccs_state_e next_state;
    logic [CCS_CNT_W-1:0] timer;
    logic [13:0] row;
    logic [13:0] col;
    ccs_gates_s gates;
    ccs_sample_s tag_in;
    logic in_ready;
    logic [1:0] occ;
    ccs_sample_s buf_q [2];
    logic wr_ptr;
    logic rd_ptr;

    // =====================================================================
    // Region decode
    function automatic ccs_tag_e classify(input logic [13:0] r, input logic [13:0] c);
        if (c < 14'(CCS_DUMMY)) begin
            return CCS_TAG_DUMMY;
        end else if (c < 14'(CCS_DUMMY + CCS_CTE_COLS)) begin
            return CCS_TAG_CTE;
        end else if (c < 14'(CCS_DUMMY + CCS_CTE_COLS + CCS_LEAD_DARK)) begin
            return CCS_TAG_DARK;
        end else if (r < 14'(CCS_TOP_DARK) || r >= 14'(CCS_ROWS - CCS_BOT_DARK)) begin
            return CCS_TAG_DARK;
        end else if (c < 14'(CCS_DUMMY + CCS_CTE_COLS + CCS_LEAD_DARK + CCS_BUFFER)
                     || r < 14'(CCS_TOP_DARK + CCS_BUFFER)
                     || r >= 14'(CCS_ROWS - CCS_BOT_DARK - CCS_BUFFER)) begin
            return CCS_TAG_BUFFER;
        end
        return CCS_TAG_ACTIVE;
    endfunction : classify

    localparam logic [13:0] BUF_COL0 = 14'(CCS_DUMMY + CCS_CTE_COLS + CCS_LEAD_DARK);
    wire logic timer_done = (timer == CCS_ZERO24);
    wire logic last_col = (col == 14'(CCS_PIX_PER_OUT - 1));
    wire logic last_row = (row == 14'(CCS_ROWS - 1));
    // In parallel split the extra pass empties the B register after the last load
    wire logic rows_done = parallel_split_i ? (row == 14'(CCS_ROWS)) : last_row;

    // Tag for the pixel presented on the current last-phase fall
    assign tag_in.row = parallel_split_i ? 14'(row - 14'h0001) : row;
    assign tag_in.col = col; // col is per output, same on each half
    assign tag_in.tag = classify(tag_in.row, col);
    assign tag_in.blue = (col >= BUF_COL0) && (col < BUF_COL0 + 14'(CCS_BLUE_COLS));
    // First pass of parallel split only loads A, nothing to sample
    wire logic pass_valid = !(parallel_split_i && row == CCS_ZERO14);

    // =====================================================================
    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (start_i) next_state = ST_COLLECT;
            ST_COLLECT: if (timer_done) next_state = ST_FLUSH;
            ST_FLUSH: if (timer_done) next_state = ST_DUMP;
            ST_DUMP: if (timer_done) next_state = ST_RELEASE;
            ST_RELEASE: if (timer_done) next_state = ST_SETTLE;
            ST_SETTLE: if (timer_done) next_state = ST_INTEG;
            ST_INTEG: if (timer_done) next_state = ST_V1;
            ST_V1: if (timer_done) next_state = ST_V2;
            ST_V2: if (timer_done) next_state = parallel_split_i ? ST_XFER : ST_HHIGH;
            ST_XFER: if (timer_done) next_state = pass_valid ? ST_HHIGH : ST_V1;
            ST_HHIGH: if (timer_done && in_ready) next_state = ST_HLOW;
            ST_HLOW: if (timer_done) next_state = ST_RESET;
            ST_RESET: if (timer_done) begin
                if (!last_col) next_state = ST_HHIGH;
                else if (rows_done) next_state = ST_IDLE;
                else next_state = ST_V1;
            end
        endcase
    end

    // =====================================================================
    // Gate levels per state
    always_comb begin
        gates = '0;
        unique case (state)
            ST_COLLECT: gates.vertical_phase_two = 1'b1;
            ST_FLUSH: begin
                gates.vertical_phase_two = 1'b1;
                gates.pixel_flush_gate = 1'b1;
            end
            ST_DUMP: begin
                gates.vertical_phase_two = 1'b1;
                gates.row_dump_gate = 1'b1;
            end
            ST_INTEG: gates = '0;
            ST_V1: begin
                gates.vertical_phase_one = 1'b1;
                gates.horizontal_phase_one_a = 1'b1;
            end
            ST_V2: begin
                gates.vertical_phase_two = 1'b1;
                gates.horizontal_phase_one_a = 1'b1;
            end
            ST_XFER: begin
                gates.horizontal_transfer_gate = 1'b1;
                gates.horizontal_phase_one_a = 1'b1; // Still high at the phase two fall
            end
            ST_HHIGH: begin
                gates.horizontal_phase_one_a = 1'b1;
                gates.last_horizontal_phase = 1'b1;
            end
            ST_RESET: gates.output_reset_gate = 1'b1;
            default: gates = '0;
        endcase
    end

    // Sample on the last-phase fall, entering ST_HLOW
    wire logic fall = (state == ST_HHIGH) && timer_done && in_ready;

    // =====================================================================
    // Timer and counters
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            timer <= CCS_ZERO24;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                unique case (next_state)
                    ST_SETTLE: timer <= CCS_CNT_W'(CCS_SETTLE_CYC - 1);
                    ST_INTEG: timer <= integ_cycles_i;
                    default: timer <= CCS_CNT_W'(CCS_PHASE_CYC - 1);
                endcase
            end else if (!timer_done) begin
                timer <= timer - 24'h00_0001;
            end
        end
    end

    // Row and column counters
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            row <= CCS_ZERO14;
            col <= CCS_ZERO14;
        end else if (state == ST_IDLE) begin
            row <= CCS_ZERO14;
            col <= CCS_ZERO14;
        end else if (state == ST_RESET && timer_done) begin
            col <= last_col ? CCS_ZERO14 : col + 14'h0001;
            if (last_col) row <= row + 14'h0001;
        end else if (state == ST_XFER && timer_done && !pass_valid) begin
            row <= row + 14'h0001;
        end
    end

    // Registered gate and strobe outputs
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gates_o <= '0;
            sample_strobe_o <= 1'b0;
            frame_done_o <= 1'b0;
        end else begin
            gates_o <= gates;
            // Strobe rises at the same edge at which gates_o drops the last phase
            sample_strobe_o <= (state == ST_HLOW) && gates_o.last_horizontal_phase;
            frame_done_o <= (state == ST_RESET) && timer_done && last_col && rows_done;
        end
    end

    assign busy_o = (state != ST_IDLE);

    // =====================================================================
    // Two-entry tag buffer; full buffer stalls the horizontal clock
    assign in_ready = (occ != 2'd2);
    assign tag_valid_o = (occ != 2'd0);
    assign tag_o = buf_q[rd_ptr];
    wire logic push = fall;
    wire logic pop = tag_valid_o && tag_ready_i;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            occ <= 2'd0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else begin
            if (push) begin
                buf_q[wr_ptr] <= tag_in;
                wr_ptr <= !wr_ptr;
            end
            if (pop) rd_ptr <= !rd_ptr;
            occ <= occ + 2'(push) - 2'(pop);
        end
    end

endmodule : ccs_sequencer

// ===== rtl/ccs_pkg.sv
/*
 Package of the frame-sequencing controller for a four-output full-frame image sensor.
 It holds the frame geometry, the gate timing counts and the sample tag types.
 It assumes that one 50 MHz clock runs every process that uses these constants.
*/
// What this block does
// - First 20 register samples are dummy
// - Vertical phases held low during integration
// - Row transfers on phase two fall, H1A high
// - Parallel split pulses transfer gate per line
// - Drain starts: phase two high, one low
// - Flush or dump gate only while two high
// - Dump row drained by the dump gate
// - Drain ends after two low plus settling
// - Pulse reset gate after each sample
package ccs_pkg;

    // =====================================================================
    // Frame geometry
    localparam int unsigned CCS_LEAD_DARK = 28;
    localparam int unsigned CCS_DUMMY = 20;
    localparam int unsigned CCS_BUFFER = 16;
    localparam int unsigned CCS_BLUE_COLS = 4;
    localparam int unsigned CCS_CTE_COLS = 2;
    localparam int unsigned CCS_TOP_DARK = 29;
    localparam int unsigned CCS_BOT_DARK = 26;
    localparam int unsigned CCS_ROWS = 6220;
    localparam int unsigned CCS_PIX_PER_OUT = 4152;

    // =====================================================================
    // Timing, in ns and as 20 ns clock counts
    localparam int unsigned CCS_CLK_NS = 20;
    localparam int unsigned CCS_PHASE_NS = 100;
    localparam int unsigned CCS_SETTLE_NS = 10000;
    localparam int unsigned CCS_PHASE_CYC = (CCS_PHASE_NS + CCS_CLK_NS - 1) / CCS_CLK_NS;
    localparam int unsigned CCS_SETTLE_CYC = (CCS_SETTLE_NS + CCS_CLK_NS - 1) / CCS_CLK_NS;
    localparam int unsigned CCS_CNT_W = 24;

    // Register reset values
    localparam logic [13:0] CCS_ZERO14 = 14'h0000;
    localparam logic [23:0] CCS_ZERO24 = 24'h00_0000;

    // =====================================================================
    // Types
    typedef enum logic [2:0] {
        CCS_TAG_DUMMY, CCS_TAG_DARK, CCS_TAG_CTE, CCS_TAG_BUFFER, CCS_TAG_ACTIVE
    } ccs_tag_e;

    typedef struct packed {
        logic [13:0] row;
        logic [13:0] col;
        ccs_tag_e tag;
        logic blue;
    } ccs_sample_s;

    typedef struct packed {
        logic vertical_phase_one;
        logic vertical_phase_two;
        logic horizontal_phase_one_a;
        logic last_horizontal_phase;
        logic horizontal_transfer_gate;
        logic pixel_flush_gate;
        logic row_dump_gate;
        logic output_reset_gate;
    } ccs_gates_s;

endpackage : ccs_pkg

// ===== verification/ccs_seq_properties.sv
/* Port checker of the frame sequencer: gate order, drain, strobe and tag handshake.
   Assumes one clock and an integration count held stable during a frame. */
`timescale 1ns/1ps
module ccs_seq_properties (
    input logic ref_clk_i,
    input logic rst_n_i,
    input logic start_i,
    input logic parallel_split_i,
    input logic [ccs_pkg::CCS_CNT_W-1:0] integ_cycles_i,
    input ccs_pkg::ccs_gates_s gates_o,
    input logic sample_strobe_o,
    input logic busy_o,
    input logic frame_done_o,
    input logic tag_valid_o,
    input logic tag_ready_i,
    input ccs_pkg::ccs_sample_s tag_o
);
    import ccs_pkg::*;
    // =====================================================================
    // Quiet spell from drain release to the first line transfer
    logic armed;
    logic [23:0] cnt;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed <= 1'b0;
            cnt <= 24'h00_0000;
        end else begin
            armed <= ($fell(gates_o.vertical_phase_two) && $past(gates_o.row_dump_gate))
                || (armed && !gates_o.vertical_phase_one);
            cnt <= armed ? cnt + 24'h00_0001 : 24'h00_0000;
        end
    end
    // Drain gates and their order
    flush_in_v2_a: assert property (gates_o.pixel_flush_gate |-> gates_o.vertical_phase_two)
        else $error("flush gate high without phase two");
    dump_in_v2_a: assert property (gates_o.row_dump_gate |-> gates_o.vertical_phase_two)
        else $error("dump gate high without phase two");
    drain_order_a: assert property ($rose(gates_o.pixel_flush_gate) |->
        $past(gates_o.vertical_phase_two, 5) && !gates_o.vertical_phase_one)
        else $error("flush before charge collected under phase two");
    dump_after_flush_a: assert property ($rose(gates_o.row_dump_gate) |->
        $past(gates_o.pixel_flush_gate)) else $error("dump row not drained after flush");
    // Line transfer, integration and settling
    row_xfer_h1a_a: assert property ($fell(gates_o.vertical_phase_two) &&
        !$past(gates_o.row_dump_gate) |-> gates_o.horizontal_phase_one_a)
        else $error("row moved with phase one a low");
    integ_hold_a: assert property (armed |-> !gates_o.vertical_phase_two)
        else $error("vertical clock during integration");
    settle_wait_a: assert property (armed && gates_o.vertical_phase_one |->
        cnt >= CCS_SETTLE_CYC + integ_cycles_i) else $error("line started too early");
    xg_mode_a: assert property (gates_o.horizontal_transfer_gate |-> parallel_split_i)
        else $error("transfer gate pulsed in dual split");
    // Pixel sampling, reset gate and tag buffer
    strobe_edge_a: assert property (sample_strobe_o == $fell(gates_o.last_horizontal_phase))
        else $error("strobe not on last phase fall");
    reset_after_a: assert property (sample_strobe_o |->
        !gates_o.output_reset_gate [*5] ##1 gates_o.output_reset_gate)
        else $error("reset gate not after sample");
    tag_hold_a: assert property (tag_valid_o && !tag_ready_i |=> tag_valid_o && $stable(tag_o))
        else $error("tag changed while stalled");
    cover property (sample_strobe_o);
    cover property (gates_o.horizontal_transfer_gate);
    cover property (tag_valid_o && !tag_ready_i);
endmodule : ccs_seq_properties

bind ccs_sequencer ccs_seq_properties i_ccs_seq_properties (.ref_clk_i, .rst_n_i, .start_i,
    .parallel_split_i, .integ_cycles_i, .gates_o, .sample_strobe_o, .busy_o, .frame_done_o,
    .tag_valid_o, .tag_ready_i, .tag_o);

// ===== verification/ccs_sensor_model.sv
/* Behavioural sensor: counts rows moved into the shift register and charge packets.
   Assumes the gate bundle of the sequencer and its clock. */
`timescale 1ns/1ps
module ccs_sensor_model (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input ccs_pkg::ccs_gates_s gates_i,
    output int rows_moved,
    output int packets
);
    import ccs_pkg::*;
    // Geometry of a line and a frame; both halves clock together
    localparam int unsigned LINE_PIX = CCS_PIX_PER_OUT;
    localparam int unsigned FRAME_ROWS = CCS_ROWS;
    ccs_gates_s prev;
    wire row_drop = prev.vertical_phase_two && !gates_i.vertical_phase_two
        && gates_i.horizontal_phase_one_a;
    wire pkt_drop = prev.last_horizontal_phase && !gates_i.last_horizontal_phase;
    // Count edge events
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev <= '0;
            rows_moved <= 0;
            packets <= 0;
        end else begin
            prev <= gates_i;
            rows_moved <= rows_moved + int'(row_drop);
            packets <= packets + int'(pkt_drop);
        end
    end
endmodule : ccs_sensor_model

// ===== verification/ccs_sequencer_test.sv
/* Self-checking bench of the frame sequencer with a sensor model.
   Assumes 50 MHz; runs the first words of a dual split and a parallel split frame. */
`timescale 1ns/1ps
module ccs_sequencer_test;
    import ccs_pkg::*;
    logic ref_clk_i, rst_n_i, start_i, parallel_split_i, tag_ready_i, stall;
    logic [CCS_CNT_W-1:0] integ_cycles_i;
    ccs_gates_s gates_o;
    ccs_sample_s tag_o;
    logic sample_strobe_o, busy_o, frame_done_o, tag_valid_o;
    int n_mismatch, comparisons, pops, rows_moved, packets;
    ccs_sequencer i_ccs_sequencer (.ref_clk_i, .rst_n_i, .start_i, .parallel_split_i,
        .integ_cycles_i, .gates_o, .sample_strobe_o, .busy_o, .frame_done_o, .tag_valid_o,
        .tag_ready_i, .tag_o);
    ccs_sensor_model i_ccs_sensor_model (.ref_clk_i, .rst_n_i, .gates_i(gates_o),
        .rows_moved, .packets);
    // =====================================================================
    // Checking helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("BAD %s exp %0h seen %0h", what, exp, seen);
            n_mismatch++;
        end
    endtask : check
    function automatic ccs_tag_e exp_tag(input int col);
        return (col < CCS_DUMMY) ? CCS_TAG_DUMMY : CCS_TAG_DARK;
    endfunction : exp_tag
    task automatic final_report();
        $display("compared %0d, mismatched %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    task automatic wait_pops(input int n);
        for (int k = 0; k < 20000 && pops < n; k++)
            @(posedge ref_clk_i);
        if (pops < n) begin
            $display("BAD wait for %0d words", n);
            n_mismatch++;
            final_report();
        end
    endtask : wait_pops
    // One frame: start, refused restart, full buffer stall, then drain words
    task automatic run_frame(input logic par, input int n);
        @(posedge ref_clk_i);
        parallel_split_i <= par;
        integ_cycles_i <= 24'(($urandom % 64));
        start_i <= 1'b1;
        stall <= 1'b1;
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        start_i <= 1'b1;
        #1 check("busy", busy_o, 1);
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        for (int k = 0; k < 5000 && tag_valid_o !== 1'b1; k++)
            @(posedge ref_clk_i);
        if (tag_valid_o !== 1'b1) begin
            $display("BAD wait for first word");
            n_mismatch++;
            final_report();
        end
        repeat (100) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        check("packets held", packets, 2);
        stall <= 1'b0;
        wait_pops(n);
        @(negedge ref_clk_i);
        check("rows", rows_moved, par ? 2 : 1);
    endtask : run_frame
    // Clock
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    // Consumer: random ready, stalls on demand, checks every word taken
    always @(posedge ref_clk_i)
        tag_ready_i <= !stall && ($urandom % 4 != 0);
    // Words are checked at the falling edge, where valid, ready and the word are settled
    always @(negedge ref_clk_i) begin
        if (!rst_n_i)
            pops <= 0;
        else if (tag_valid_o === 1'b1 && tag_ready_i === 1'b1) begin
            check("row", tag_o.row, 0);
            check("col", tag_o.col, pops);
            if (pops < 50 && (pops < CCS_DUMMY || pops >= CCS_DUMMY + CCS_CTE_COLS))
                check("tag", tag_o.tag, exp_tag(pops));
            pops <= pops + 1;
        end
    end
    // Main sequence, with a reset in mid-frame between the two modes
    initial begin
        rst_n_i = 1'b0;
        start_i = 1'b0;
        parallel_split_i = 1'b0;
        stall = 1'b1;
        integ_cycles_i = 24'h00_0000;
        n_mismatch = 0;
        comparisons = 0;
        void'($urandom(32'h0000_e2d9));
        repeat (5) @(posedge ref_clk_i);
        check("gates idle", gates_o, 8'h00);
        rst_n_i <= 1'b1;
        run_frame(1'b0, 60);
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        run_frame(1'b1, 60);
        final_report();
    end
endmodule : ccs_sequencer_test
